// ===== src/adc_boundary_scan_cells.sv
// Purpose: Boundary-scan control and observe cells at the converter.
// Assumes: Test port levels change after the falling test clock edge.
// Assumes: Test clock is far slower than core_clk (160 ns here).
// Notes: Cells capture and shift on rising, update on falling edges.
`timescale 1ns/1ps
`include "adc_scan_map.svh"

module adc_boundary_scan_cells
    import adc_scan_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    // Test access port levels; all but tdo are asynchronous to core_clk.
    input wire logic tck,
    input wire logic tdi,
    input wire logic chainSelected,
    input wire logic captureDr,
    input wire logic shiftDr,
    input wire logic updateDr,
    output logic tdo,
    // Comparator result from the converter macro, asynchronous.
    input wire logic comparatorOut,
    // Controls applied to the converter macro.
    output adc_ctrl_t convCtrl,
    // Plain register port.
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWriteData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regReadData
);

    scan_state_t state_q;
    scan_state_t state_d;
    tap_ctrl_t tapIn;
    tap_ctrl_t tapSync;
    logic compSync;
    logic [`SYNC_WIDTH-1:0] syncRaw;
    logic [`SYNC_WIDTH-1:0] syncVec;
    logic tckRise;
    logic tckFall;

    // Recommended idle pattern, the state of an unused converter.
    function automatic adc_ctrl_t idleCells();
        adc_ctrl_t c;
        c.ampClock = `IDLE_AMP_CLOCK;
        c.ampToComparatorPathEn = `IDLE_PATH_EN;
        c.bandgapNegInputEn = `IDLE_BG_NEG;
        c.converterPowerOn = `IDLE_POWER_ON;
        c.diffAmpPowerOn = `IDLE_AMP_POWER;
        c.dacCode = `IDLE_DAC_CODE;
        c.ampBypassRoute = `IDLE_BYPASS;
        c.negInputGround = `IDLE_NEG_GROUND;
        c.sampleHold = `IDLE_SAMPLE_HOLD;
        c.bandgapAsDacReference = `IDLE_BG_REF;
        c.inputSelect = `IDLE_INPUT_SELECT;
        return c;
    endfunction

    // Gather the asynchronous levels for the synchroniser.
    always_comb
    begin
        tapIn.tck = tck;
        tapIn.tdi = tdi;
        tapIn.chainSelected = chainSelected;
        tapIn.captureDr = captureDr;
        tapIn.shiftDr = shiftDr;
        tapIn.updateDr = updateDr;
    end

    assign syncRaw = {tapIn, comparatorOut};

    scan_input_sync inputSync
    (
        .core_clk(core_clk),
        .srst(srst),
        .asyncIn(syncRaw),
        .syncOut(syncVec)
    );

    // Split the synchronised levels back into their fields.
    assign {tapSync, compSync} = syncVec;

    // Test clock edges found by the core clock.
    assign tckRise = tapSync.tck & ~state_q.tapPrev.tck;
    assign tckFall = ~tapSync.tck & state_q.tapPrev.tck;

    // Next state of the whole block.
    always_comb
    begin
        state_d = state_q;
        state_d.tapPrev = tapSync;

        // Capture and shift act on the levels held before the edge.
        if (tckRise && state_q.tapPrev.chainSelected)
        begin
            if (state_q.tapPrev.captureDr)
            begin
                state_d.shiftReg = {state_q.update, compSync};
            end
            else if (state_q.tapPrev.shiftDr)
            begin
                // Shift in at the top, out from the observe end.
                state_d.shiftReg = {state_q.tapPrev.tdi,
                    state_q.shiftReg[`CHAIN_LEN-1:1]};
            end
        end

        // Update latches take the shifted pattern on the falling edge.
        if (tckFall && state_q.tapPrev.chainSelected &&
            state_q.tapPrev.updateDr)
        begin
            state_d.update = state_q.shiftReg[`CHAIN_LEN-1:1];
        end

        // Output is presented on the falling edge, as the port expects.
        if (tckFall)
        begin
            state_d.tdo = state_q.shiftReg[0];
        end

        // Converter sees the latches only while software allows it.
        if (state_q.driveEn)
        begin
            state_d.convOut.ampClock = state_q.update.ampClock;
            state_d.convOut.ampToComparatorPathEn =
                state_q.update.ampToComparatorPathEn;
            state_d.convOut.bandgapNegInputEn =
                state_q.update.bandgapNegInputEn;
            state_d.convOut.converterPowerOn =
                state_q.update.converterPowerOn;
            state_d.convOut.diffAmpPowerOn = state_q.update.diffAmpPowerOn;
            state_d.convOut.dacCode = state_q.update.dacCode;
            state_d.convOut.ampBypassRoute = state_q.update.ampBypassRoute;
            state_d.convOut.negInputGround = state_q.update.negInputGround;
            state_d.convOut.sampleHold = state_q.update.sampleHold;
            state_d.convOut.bandgapAsDacReference =
                state_q.update.bandgapAsDacReference;
            state_d.convOut.inputSelect = state_q.update.inputSelect;
        end
        else
        begin
            // Quiet converter while software keeps the cells off.
            state_d.convOut = idleCells();
        end

        // Software write to the control register.
        if (regWrite)
        begin
            if (regAddr == `REG_CTRL)
            begin
                state_d.driveEn = regWriteData[`CTRL_DRIVE_BIT];
            end
        end

        // Read data stand for one cycle after the strobe only.
        state_d.readData = '0;
        if (regRead)
        begin
            if (regAddr == `REG_CTRL)
            begin
                state_d.readData[`CTRL_DRIVE_BIT] = state_q.driveEn;
            end
            else if (regAddr == `REG_APPLIED)
            begin
                state_d.readData[`CHAIN_LEN-2:0] = state_q.update;
            end
            else if (regAddr == `REG_STATUS)
            begin
                state_d.readData[`STATUS_COMP_BIT] = compSync;
                state_d.readData[`STATUS_DRIVE_BIT] = state_q.driveEn;
            end
            else
            begin
                state_d.readData = '0; // Unmapped reads return zero.
            end
        end
    end

    // Register the state; reset loads the idle pattern into update and convOut, zeros elsewhere.
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            state_q.tapPrev <= '0;
            state_q.shiftReg <= `SHIFT_RESET;
            state_q.update <= idleCells();
            state_q.driveEn <= `CTRL_DRIVE_RESET;
            state_q.convOut <= idleCells();
            state_q.tdo <= 1'h0;
            state_q.readData <= 32'h00000000;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // Outputs come straight from the state flops.
    assign tdo = state_q.tdo;
    assign convCtrl = state_q.convOut;
    assign regReadData = state_q.readData;

    // The test controller keeps hold against the amplifier clock and
    // the DAC steady while sampling; nothing here enforces either.
    // relies on controller

endmodule

// ===== src/adc_scan_map.svh
// Purpose: Constants for the converter boundary-scan cells.
// Assumes: Included by its bare name after the package.
// Notes: Offsets are byte addresses on the plain register port.
`ifndef ADC_SCAN_MAP_SVH
`define ADC_SCAN_MAP_SVH

// Chain geometry: observe cell at bit 0, control cells above it.
`define CHAIN_LEN 28
`define SYNC_WIDTH 7

// Register offsets on the software port.
`define REG_CTRL 4'h0
`define REG_APPLIED 4'h4
`define REG_STATUS 4'h8

// Field positions.
`define CTRL_DRIVE_BIT 0
`define STATUS_COMP_BIT 0
`define STATUS_DRIVE_BIT 1

// Reset values.
`define CTRL_DRIVE_RESET 1'h0
`define SHIFT_RESET 28'h0000000

// Recommended idle values of the control cells.
`define IDLE_AMP_CLOCK 1'h0
`define IDLE_PATH_EN 1'h0
`define IDLE_BG_NEG 1'h0
`define IDLE_POWER_ON 1'h0
`define IDLE_AMP_POWER 1'h0
`define IDLE_DAC_CODE 10'h200
`define IDLE_BYPASS 1'h1
`define IDLE_NEG_GROUND 1'h0
`define IDLE_SAMPLE_HOLD 1'h1
`define IDLE_BG_REF 1'h0
`define IDLE_INPUT_SELECT 8'h01

`endif

// ===== src/adc_scan_pkg.sv
// Purpose: Types shared by the converter boundary-scan cells.
// Assumes: Constants come from adc_scan_map.svh.
// Notes: Field order of adc_ctrl_t is the shift order, top first.
package adc_scan_pkg;

    // Digital controls that the cells apply to the converter macro.
    typedef struct packed {
        logic ampClock;
        logic ampToComparatorPathEn;
        logic bandgapNegInputEn;
        logic converterPowerOn;
        logic diffAmpPowerOn;
        logic [9:0] dacCode;
        logic ampBypassRoute;
        logic negInputGround;
        logic sampleHold;
        logic bandgapAsDacReference;
        logic [7:0] inputSelect;
    } adc_ctrl_t;

    // Levels coming from the test access port controller.
    typedef struct packed {
        logic tck;
        logic tdi;
        logic chainSelected;
        logic captureDr;
        logic shiftDr;
        logic updateDr;
    } tap_ctrl_t;

    // State of the two-flop synchroniser.
    typedef struct packed {
        logic [6:0] first;
        logic [6:0] second;
    } sync_pair_t;

    // State of the scan cell block.
    typedef struct packed {
        tap_ctrl_t tapPrev;
        logic [27:0] shiftReg;
        adc_ctrl_t update;
        logic driveEn;
        adc_ctrl_t convOut;
        logic tdo;
        logic [31:0] readData;
    } scan_state_t;

endpackage

// ===== src/scan_input_sync.sv
// Purpose: Two-flop synchroniser for the scan pins and comparator.
// Assumes: All inputs are asynchronous levels.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
`include "adc_scan_map.svh"

module scan_input_sync
    import adc_scan_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [`SYNC_WIDTH-1:0] asyncIn,
    output logic [`SYNC_WIDTH-1:0] syncOut
);

    sync_pair_t state_q;
    sync_pair_t state_d;

    // Shift the asynchronous levels through two stages.
    always_comb
    begin
        state_d = state_q;
        state_d.first = asyncIn;
        state_d.second = state_q.first;
    end

    // Register the stages; reset clears both.
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            state_q <= '0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign syncOut = state_q.second;

endmodule

// ===== test/adc_scan_asserts.sv
// Purpose: Port checker for the converter scan cells.
// Assumes: Sees only the ports of the block's top module.
// Notes: The bind to the block follows the module.
`timescale 1ns/1ps
`include "adc_scan_map.svh"
module adc_scan_asserts
    import adc_scan_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic tck,
    input wire logic tdo,
    input wire logic comparatorOut,
    input wire adc_ctrl_t convCtrl,
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWriteData,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [31:0] regReadData
);
    // Idle pattern: DAC 0x200, hold, bypass and lowest mux bit set.
    localparam logic [26:0] IDLE = 27'h200a01;
    logic [3:0] quietCnt_q;
    // Counts core cycles since the test clock last moved.
    always_ff @(posedge core_clk)
    begin
        if (srst || tck != $past(tck))
            quietCnt_q <= 4'h0;
        else if (quietCnt_q != 4'hf)
            quietCnt_q <= quietCnt_q + 4'h1;
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);
    // Enabling the drive, then reading the latches with the link quiet.
    sequence driveOnThenRead;
        regWrite && regAddr == `REG_CTRL && regWriteData[0] ##1
            regRead && regAddr == `REG_APPLIED && quietCnt_q > 4'h8;
    endsequence
    a_reset_idle: assert property (
        disable iff (1'b0) srst |=> convCtrl == IDLE)
        else $error("Controls not idle after reset.");
    a_drive_off_idle: assert property (
        regWrite && regAddr == `REG_CTRL && !regWriteData[0]
        |-> ##2 convCtrl == IDLE) else $error("Controls not idle.");
    a_drive_follow: assert property (
        driveOnThenRead |=> regReadData[26:0] == convCtrl)
        else $error("Controls differ from the latches.");
    a_ctrl_quiet: assert property (
        quietCnt_q > 4'h8 && !$past(regWrite) && !$past(regWrite, 2)
        |-> $stable(convCtrl)) else $error("Controls moved alone.");
    a_tdo_quiet: assert property (
        quietCnt_q > 4'h8 |-> $stable(tdo))
        else $error("Serial out moved without a clock.");
    a_comp_status: assert property (
        $stable(comparatorOut)[*4] ##0 (regRead && regAddr == `REG_STATUS)
        |=> regReadData[0] == $past(comparatorOut))
        else $error("Status does not show the comparator.");
    a_read_one_cycle: assert property (
        !regRead |=> regReadData == 32'h0)
        else $error("Read data stood too long.");
    a_unmapped_zero: assert property (
        regRead && !(regAddr inside {`REG_CTRL, `REG_APPLIED, `REG_STATUS})
        |=> regReadData == 32'h0) else $error("Unmapped read not zero.");
endmodule
bind adc_boundary_scan_cells adc_scan_asserts chk_u (
    .core_clk(core_clk), .srst(srst), .tck(tck), .tdo(tdo),
    .comparatorOut(comparatorOut), .convCtrl(convCtrl),
    .regAddr(regAddr), .regWriteData(regWriteData),
    .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData)
);

// ===== test/jtag_ctrl_model.sv
// Purpose: Test controller model that shifts the scan chain.
// Assumes: Its clock stands low outside frames.
// Notes: Levels change 20 ns after each falling test clock edge.
`timescale 1ns/1ps
module jtag_ctrl_model
(
    output logic tck,
    output logic tdi,
    output logic chainSelected,
    output logic captureDr,
    output logic shiftDr,
    output logic updateDr,
    input wire logic tdo
);
    // All levels start low.
    initial
    begin
        {tck, tdi, chainSelected, captureDr, shiftDr, updateDr} = 6'h0;
    end
    // One 160 ns test clock period; serial out is read before the rise.
    task automatic tick(input logic [3:0] lv, input logic d,
        output logic q);
        begin
            {chainSelected, captureDr, shiftDr, updateDr} = lv;
            tdi = lv[1] ? d : ~tdi; // An unused data line keeps toggling.
            #60 q = tdo;
            tck = 1'b1;
            #80 tck = 1'b0;
            #20;
        end
    endtask
    // Capture, 28 shifts with the first bit in first out, then update.
    task automatic scan(input logic sel, input logic [27:0] din,
        output logic [27:0] dout);
        logic q;
        begin
            // Move every level change off the core clock edges.
            #3;
            tick({sel, 3'b100}, 1'b0, q);
            for (int i = 0; i < 28; i++)
            begin
                tick({sel, 3'b010}, din[i], dout[i]);
            end
            tick({sel, 3'b001}, 1'b0, q);
        end
    endtask
endmodule

// ===== test/test_adc_boundary_scan_cells.sv
// Purpose: Self-checking bench for the converter scan cells.
// Assumes: The model drives the link; the bench drives registers.
// Notes: Each control cell is flipped from idle once, one per scan.
`timescale 1ns/1ps
`include "adc_scan_map.svh"
module test_adc_boundary_scan_cells
    import adc_scan_pkg::*;
;
    localparam logic [26:0] IDLE = 27'h200a01;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic comparatorOut = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [31:0] regWriteData = 32'h0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic tck, tdi, chainSelected, captureDr, shiftDr, updateDr, tdo;
    adc_ctrl_t convCtrl;
    logic [31:0] regReadData;
    logic [27:0] dout;
    logic [26:0] vec, prev;
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;
    adc_boundary_scan_cells dut_u (.core_clk(core_clk), .srst(srst),
        .tck(tck), .tdi(tdi), .chainSelected(chainSelected),
        .captureDr(captureDr), .shiftDr(shiftDr), .updateDr(updateDr),
        .tdo(tdo), .comparatorOut(comparatorOut), .convCtrl(convCtrl),
        .regAddr(regAddr), .regWriteData(regWriteData),
        .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData));
    jtag_ctrl_model model_u (.tck(tck), .tdi(tdi),
        .chainSelected(chainSelected), .captureDr(captureDr),
        .shiftDr(shiftDr), .updateDr(updateDr), .tdo(tdo));
    // Core clock and the cycle ceiling.
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            failures++;
            summarize();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        begin
            comparisons++;
            if (got !== exp)
            begin
                failures++;
                $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        begin
            regAddr <= a;
            regWriteData <= d;
            regWrite <= 1'b1;
            @(posedge core_clk);
            regWrite <= 1'b0;
        end
    endtask
    task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
        begin
            regAddr <= a;
            regRead <= 1'b1;
            @(posedge core_clk);
            regRead <= 1'b0;
            #1 chk(regReadData, exp);
            @(posedge core_clk);
        end
    endtask
    task automatic summarize();
        begin
            $display("comparisons=%0d failures=%0d", comparisons, failures);
            if (failures == 0 && comparisons > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    // Main sequence: reset, per-cell scans, drive off, refused scan.
    initial
    begin
        repeat (6) @(posedge core_clk);
        srst <= 1'b0;
        repeat (3) @(posedge core_clk);
        chk({5'h0, convCtrl}, {5'h0, IDLE});
        rdc(`REG_APPLIED, {5'h0, IDLE});
        rdc(4'hc, 32'h0);
        $display("test reset done");
        wr(`REG_CTRL, 32'h1);
        prev = IDLE;
        for (int i = 0; i < 27; i++)
        begin
            vec = IDLE ^ (27'h1 << i);
            comparatorOut <= i[0];
            model_u.scan(1'b1, {vec, 1'b0}, dout);
            repeat (7) @(posedge core_clk);
            chk({4'h0, dout}, {4'h0, prev, i[0]});
            chk({5'h0, convCtrl}, {5'h0, vec});
            prev = vec;
        end
        $display("test cell scans done");
        wr(`REG_CTRL, 32'h0);
        repeat (2) @(posedge core_clk);
        chk({5'h0, convCtrl}, {5'h0, IDLE});
        comparatorOut <= 1'b1;
        model_u.scan(1'b0, 28'hfffffff, dout);
        repeat (7) @(posedge core_clk);
        chk({4'h0, dout}, 32'h0);
        rdc(`REG_STATUS, 32'h1);
        wr(`REG_CTRL, 32'h1);
        rdc(`REG_APPLIED, {5'h0, prev});
        chk({5'h0, convCtrl}, {5'h0, prev});
        $display("test refused scan done");
        summarize();
    end
endmodule
